/* quad_rate_burst4_sram_port.sv */
// device side of a burst-of-four double data rate static memory with
// separate read and write data ports and one shared address bus
// assumes in_clk and in_clk_n are a free running complementary pair from
// the host, and clk is an unrelated internal clock for the array writer
`timescale 1ns/100ps
`include "burst4_sram_defines.svh"

module quad_rate_burst4_sram_port #(
  parameter int DATA_W = `DEF_DATA_W,
  parameter int ADDR_W = `DEF_ADDR_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_clk,
  input wire logic in_clk_n,
  input wire logic pll_bypass,
  input wire logic rd_sel_n,
  input wire logic wr_sel_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  output logic [DATA_W-1:0] rd_data_rise_r,
  output logic [DATA_W-1:0] rd_data_fall_r,
  output logic echo_clock_r,
  output logic echo_clock_n_r,
  output logic wr_room_r,
  output logic [ADDR_W-1:0] commit_addr_r,
  output logic commit_pulse_r
);

  localparam int BURST_W = `BURST_WORDS * DATA_W;
  localparam int DEPTH = 2 ** ADDR_W;

  // ==========================================================
  // link reset and static strap synchronisers

  logic link_rst_meta_r;
  logic link_rst_r;
  logic byp_meta_r;
  logic byp_r;

  // reset asserts at once, releases on the link clock
  always_ff @(posedge in_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {link_rst_meta_r, link_rst_r} <= `RST_ASSERTED;
    end else begin
      link_rst_meta_r <= 1'h0;
      link_rst_r <= link_rst_meta_r;
    end
  end

  // latency select pin is asynchronous to the link
  always_ff @(posedge in_clk or posedge link_rst_r) begin
    if (link_rst_r) begin
      byp_meta_r <= 1'h0;
      byp_r <= 1'h0;
    end else begin
      byp_meta_r <= pll_bypass;
      byp_r <= byp_meta_r;
    end
  end

  // ==========================================================
  // input registers on rising edges of the true and complement clocks

  logic [ADDR_W-1:0] in_addr_r;
  logic in_rsel_n_r;
  logic in_wsel_n_r;
  logic [DATA_W-1:0] in_dr_r;
  logic [DATA_W-1:0] in_df_r;
  logic phase_r;
  logic in_phase_r;

  // address, selects and rising word captured on the true clock
  always_ff @(posedge in_clk or posedge link_rst_r) begin
    if (link_rst_r) begin
      in_addr_r <= '0;
      in_rsel_n_r <= `SEL_IDLE_N;
      in_wsel_n_r <= `SEL_IDLE_N;
      in_dr_r <= '0;
      phase_r <= `PHASE_READ;
      in_phase_r <= `PHASE_READ;
    end else begin
      in_addr_r <= addr; // R7
      in_rsel_n_r <= rd_sel_n; // R7
      in_wsel_n_r <= wr_sel_n; // R7
      in_dr_r <= wr_data; // R3
      phase_r <= ~phase_r; // R1
      in_phase_r <= phase_r; // R1
    end
  end

  // second word of each pair captured on the complement rising edge
  always_ff @(posedge in_clk_n or posedge link_rst_r) begin
    if (link_rst_r) begin
      in_df_r <= '0;
    end else begin
      in_df_r <= wr_data; // R4
    end
  end

  // even edges carry a read address, odd edges a write address
  logic rd_go;
  logic wr_go;
  assign rd_go = (in_phase_r == `PHASE_READ) && !in_rsel_n_r; // R11
  assign wr_go = (in_phase_r == `PHASE_WRITE) && !in_wsel_n_r; // R11

  // ==========================================================
  // write burst assembly

  logic asm_open_r;
  logic [ADDR_W-1:0] asm_addr_r;
  logic [DATA_W-1:0] asm_w0_r;
  logic [DATA_W-1:0] asm_w1_r;
  logic [BURST_W-1:0] asm_burst;

  // words 0 and 1 arrive with the address, words 2 and 3 one cycle on
  always_ff @(posedge in_clk or posedge link_rst_r) begin
    if (link_rst_r) begin
      asm_open_r <= 1'h0;
      asm_addr_r <= '0;
      asm_w0_r <= '0;
      asm_w1_r <= '0;
    end else begin
      asm_open_r <= wr_go; // R14
      if (wr_go) begin
        asm_addr_r <= in_addr_r;
        asm_w0_r <= in_dr_r; // R2
        asm_w1_r <= in_df_r; // R2
      end
    end
  end

  // word k of a burst sits at bits k*DATA_W
  assign asm_burst = {in_df_r, in_dr_r, asm_w1_r, asm_w0_r}; // R2

  // ==========================================================
  // two-slot write buffer and request handshake toward the writer

  logic [ADDR_W-1:0] slot_addr_r [`SLOT_COUNT];
  logic [BURST_W-1:0] slot_data_r [`SLOT_COUNT];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic busy_r;
  logic req_tog_r;
  logic ack_meta_r;
  logic ack_s_r;
  logic ack_d_r;
  logic ack_tog_r;
  logic push;
  logic pop;

  // a burst that meets a full buffer is dropped; wr_room_r warns first
  assign push = asm_open_r && (cnt_r != `SLOT_COUNT);
  assign pop = ack_s_r ^ ack_d_r;

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  // writer acknowledge passes two flops before the edge detect
  always_ff @(posedge in_clk or posedge link_rst_r) begin
    if (link_rst_r) begin
      ack_meta_r <= 1'h0;
      ack_s_r <= 1'h0;
      ack_d_r <= 1'h0;
    end else begin
      ack_meta_r <= ack_tog_r;
      ack_s_r <= ack_meta_r;
      ack_d_r <= ack_s_r;
    end
  end

  // slot storage, pointers and fill level
  always_ff @(posedge in_clk or posedge link_rst_r) begin
    if (link_rst_r) begin
      for (int i = 0; i < `SLOT_COUNT; i++) begin
        slot_addr_r[i] <= '0;
        slot_data_r[i] <= '0;
      end
      wp_r <= 1'h0;
      rp_r <= 1'h0;
      cnt_r <= 2'h0;
      wr_room_r <= 1'h1;
    end else begin
      if (push) begin
        slot_addr_r[wp_r] <= asm_addr_r;
        slot_data_r[wp_r] <= asm_burst;
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_nxt;
      wr_room_r <= (cnt_nxt != `SLOT_COUNT);
    end
  end

  // head slot is offered to the writer; it stays put until acknowledged
  always_ff @(posedge in_clk or posedge link_rst_r) begin
    if (link_rst_r) begin
      busy_r <= 1'h0;
      req_tog_r <= 1'h0;
    end else if (pop) begin
      busy_r <= 1'h0;
    end else if (!busy_r && (cnt_r != 2'h0)) begin
      busy_r <= 1'h1;
      req_tog_r <= ~req_tog_r; // R10
    end
  end

  // ==========================================================
  // self-timed array writer on the internal clock

  logic [BURST_W-1:0] mem_r [DEPTH];
  logic req_meta_r;
  logic req_s_r;
  logic req_d_r;
  logic req_ev;

  assign req_ev = req_s_r ^ req_d_r;

  // request toggle synchroniser, then commit and acknowledge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_meta_r <= 1'h0;
      req_s_r <= 1'h0;
      req_d_r <= 1'h0;
      ack_tog_r <= 1'h0;
      commit_addr_r <= '0;
      commit_pulse_r <= 1'h0;
    end else begin
      req_meta_r <= req_tog_r;
      req_s_r <= req_meta_r;
      req_d_r <= req_s_r;
      commit_pulse_r <= req_ev;
      if (req_ev) begin
        ack_tog_r <= ~ack_tog_r; // R10
        commit_addr_r <= slot_addr_r[rp_r];
      end
    end
  end

  // array storage; the head slot is stable while its request is open
  always_ff @(posedge clk) begin
    if (req_ev) begin
      mem_r[slot_addr_r[rp_r]] <= slot_data_r[rp_r]; // R10
    end
  end

  // ==========================================================
  // read fetch with forwarding from pending writes

  logic [BURST_W-1:0] fetch;
  logic slot_idx;

  // oldest source first, so the newest match overrides the rest
  always_comb begin
    slot_idx = 1'h0;
    fetch = mem_r[in_addr_r];
    for (int i = 0; i < `SLOT_COUNT; i++) begin
      slot_idx = rp_r ^ 1'(i);
      if ((2'(i) < cnt_r) && (slot_addr_r[slot_idx] == in_addr_r)) begin
        fetch = slot_data_r[slot_idx]; // R13
      end
    end
    if (asm_open_r && (asm_addr_r == in_addr_r)) begin
      fetch = asm_burst; // R13
    end
  end

  // ==========================================================
  // read beat sequencer and output registers

  burst4_sram_pkg::rd_stage_type rd_stage_r;
  logic [BURST_W-1:0] rd_burst_r;
  logic lat15_r;
  logic [DATA_W-1:0] rise_nxt;

  // word for the next true rising edge
  always_comb begin
    case (rd_stage_r)
      burst4_sram_pkg::RD_BEAT1: begin
        rise_nxt = lat15_r ? rd_burst_r[DATA_W +: DATA_W] : rd_burst_r[2*DATA_W +: DATA_W];
      end
      burst4_sram_pkg::RD_BEAT2: begin
        rise_nxt = lat15_r ? rd_burst_r[3*DATA_W +: DATA_W] : '0; // R5
      end
      default: begin
        rise_nxt = '0;
      end
    endcase
    if (rd_go && !byp_r) begin
      rise_nxt = fetch[DATA_W-1:0]; // R6
    end
  end

  // read port runs apart from the write path
  always_ff @(posedge in_clk or posedge link_rst_r) begin
    if (link_rst_r) begin
      rd_stage_r <= burst4_sram_pkg::RD_IDLE;
      rd_burst_r <= '0;
      lat15_r <= 1'h0;
      rd_data_rise_r <= '0;
      echo_clock_r <= 1'h0;
    end else begin
      rd_data_rise_r <= rise_nxt; // R8
      echo_clock_r <= ~echo_clock_r; // R12
      if (rd_go) begin
        rd_burst_r <= fetch; // R9
        lat15_r <= byp_r; // R5
        rd_stage_r <= burst4_sram_pkg::RD_BEAT1;
      end else begin
        case (rd_stage_r)
          burst4_sram_pkg::RD_BEAT1: begin
            rd_stage_r <= burst4_sram_pkg::RD_BEAT2;
          end
          default: begin
            rd_stage_r <= burst4_sram_pkg::RD_IDLE;
          end
        endcase
      end
    end
  end

  // complement edge words: 0 and 2 at 1.5 cycles, 1 and 3 at one cycle
  always_ff @(posedge in_clk_n or posedge link_rst_r) begin
    if (link_rst_r) begin
      rd_data_fall_r <= '0;
      echo_clock_n_r <= 1'h0;
    end else begin
      echo_clock_n_r <= ~echo_clock_n_r; // R12
      case (rd_stage_r)
        burst4_sram_pkg::RD_BEAT1: begin
          rd_data_fall_r <= lat15_r ? rd_burst_r[DATA_W-1:0] : rd_burst_r[DATA_W +: DATA_W];
        end
        burst4_sram_pkg::RD_BEAT2: begin
          rd_data_fall_r <= lat15_r ? rd_burst_r[2*DATA_W +: DATA_W]
                                    : rd_burst_r[3*DATA_W +: DATA_W]; // R8
        end
        default: begin
          rd_data_fall_r <= '0;
        end
      endcase
    end
  end

endmodule

/* burst4_sram_defines.svh */
// constants for the burst-of-four double data rate static memory port
// assumes it is included by bare name before any module that uses it
//
// Behaviour
// (R1) read and write addresses alternate on rising edges
// (R2) each address holds four words, burst sequentially
// (R3) data crosses on both true and complement edges
// (R4) only rising edges of the timing pair count
// (R5) bypass high: read data 1.5 cycles later
// (R6) bypass low: read data one cycle later
// (R7) all synchronous inputs land in input registers
// (R8) read data leaves from output registers
// (R9) reads and writes proceed independently, concurrently
// (R10) array write completes self-timed, no extra strobe
// (R11) each port acts only when selected
// (R12) echo timing outputs run beside read data
// (R13) reads return newest data, even pending writes
// (R14) host presents four write words consecutively
`ifndef BURST4_SRAM_DEFINES_SVH
`define BURST4_SRAM_DEFINES_SVH

// ==========================================================
// burst and geometry
`define BURST_WORDS 4
`define DEF_DATA_W 36
`define DEF_ADDR_W 6
`define SLOT_COUNT 2'h2

// ==========================================================
// address phase meaning and reset values
`define PHASE_READ 1'h0
`define PHASE_WRITE 1'h1
`define SEL_IDLE_N 1'h1
`define RST_ASSERTED 2'h3

`endif

/* burst4_sram_pkg.sv */
// types shared by the burst-of-four memory port
// assumes nothing of its surroundings
package burst4_sram_pkg;

  // ==========================================================
  // read output beat sequencer
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_BEAT1 = 2'b01,
    RD_BEAT2 = 2'b10
  } rd_stage_type;

endpackage

/* burst4_checker_assertions.sv */
// checker for the burst-of-four memory port, bound to its top module
// assumes link clocks run free and the host holds a select for one edge
`timescale 1ns/100ps
module burst4_checker #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 6
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_clk,
  input wire logic in_clk_n,
  input wire logic pll_bypass,
  input wire logic rd_sel_n,
  input wire logic wr_sel_n,
  input wire logic [DATA_W-1:0] rd_data_rise_r,
  input wire logic [DATA_W-1:0] rd_data_fall_r,
  input wire logic echo_clock_r,
  input wire logic echo_clock_n_r,
  input wire logic wr_room_r,
  input wire logic [ADDR_W-1:0] commit_addr_r,
  input wire logic commit_pulse_r
);
  // ==========================================
  // helpers
  // link rises since reset, saturating at three
  logic [1:0] up_r;
  always_ff @(posedge in_clk or posedge sys_rst) begin
    if (sys_rst) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end
  // commit strobe is one clock wide
  sequence s_pulse;
    commit_pulse_r ##1 !commit_pulse_r;
  endsequence
  // ==========================================
  // properties
  property p_echo;
    @(posedge in_clk) disable iff (sys_rst) up_r == 2'h3 |=> $changed(echo_clock_r);
  endproperty
  a_echo: assert property (p_echo) else $error("echo stuck");
  property p_echo_n;
    @(posedge in_clk_n) disable iff (sys_rst) up_r == 2'h3 |=> $changed(echo_clock_n_r);
  endproperty
  a_echo_n: assert property (p_echo_n) else $error("echo n stuck");
  property p_lat_one;
    @(posedge in_clk) disable iff (sys_rst) !pll_bypass && rd_data_rise_r != '0
      |-> !$past(rd_sel_n, 2) || !$past(rd_sel_n, 3);
  endproperty
  a_lat_one: assert property (p_lat_one) else $error("rise word late");
  property p_lat_half;
    @(posedge in_clk) disable iff (sys_rst) pll_bypass && rd_data_rise_r != '0
      |-> !$past(rd_sel_n, 3) || !$past(rd_sel_n, 4);
  endproperty
  a_lat_half: assert property (p_lat_half) else $error("rise word early");
  property p_fall;
    @(posedge in_clk_n) disable iff (sys_rst) rd_data_fall_r != '0
      |-> !$past(rd_sel_n, 3) || !$past(rd_sel_n, 4);
  endproperty
  a_fall: assert property (p_fall) else $error("fall word stray");
  property p_room;
    @(posedge in_clk) disable iff (sys_rst) $fell(wr_room_r)
      |-> !$past(wr_sel_n, 3) || !$past(wr_sel_n, 4);
  endproperty
  a_room: assert property (p_room) else $error("room lost");
  property p_pulse;
    @(posedge clk) disable iff (sys_rst) $rose(commit_pulse_r) |-> s_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("commit wide");
  property p_caddr;
    @(posedge clk) disable iff (sys_rst) $changed(commit_addr_r)
      |-> commit_pulse_r || $past(commit_pulse_r);
  endproperty
  a_caddr: assert property (p_caddr) else $error("commit addr");
endmodule

/* host_model.sv */
// host model: link clock pair, address, selects, write words, read capture
// assumes the first link rise after link reset release is a read edge
`timescale 1ns/100ps
module host_model (
  input wire logic sys_rst,
  output logic in_clk,
  output logic in_clk_n,
  output logic rd_sel_n,
  output logic wr_sel_n,
  output logic [5:0] addr,
  output logic [35:0] wr_data,
  input wire logic [35:0] rd_data_rise_r,
  input wire logic [35:0] rd_data_fall_r
);
  int n = 0;
  event wr_go;
  // ==========================================
  // free running clock pair, phase offset from the system clock
  assign in_clk_n = ~in_clk;
  initial begin
    in_clk = 1'b0;
    rd_sel_n = 1'b1;
    wr_sel_n = 1'b1;
    addr = 6'h00;
    wr_data = 36'h0;
    #1.3;
    forever #7.5 in_clk = ~in_clk;
  end
  // rises since reset; an even count means the next rise is a read edge
  always @(posedge in_clk or posedge sys_rst) begin
    n <= sys_rst ? 0 : n + 1;
  end
  // wait until the next rise has the wanted phase
  task automatic to_edge(input int wr);
    do begin
      @(posedge in_clk);
      #0.5;
    end while (n % 2 != wr || n < 2);
  endtask
  // four words on consecutive rises of the pair, from the write edge on
  task automatic put(input logic [5:0] a, input logic [143:0] d, input logic sel);
    addr = a;
    wr_sel_n = ~sel;
    wr_data = d[35:0];
    @(posedge in_clk);
    #0.5;
    wr_sel_n = 1'b1;
    wr_data = d[71:36];
    @(posedge in_clk_n);
    #0.5;
    wr_data = d[107:72];
    @(posedge in_clk);
    #0.5;
    wr_data = d[143:108];
    @(posedge in_clk_n);
    #0.5;
  endtask
  // one burst at the next write edge
  task automatic wr(input logic [5:0] a, input logic [143:0] d, input logic sel);
    to_edge(1);
    -> wr_go;
    put(a, d, sel);
    wr_data = ~d[143:108];  // released data shows the inverse
  endtask
  // two bursts on consecutive write edges, filling both buffer slots
  task automatic wr2(input logic [5:0] a, input logic [143:0] d0, input logic [143:0] d1);
    to_edge(1);
    put(a, d0, 1'b1);
    put(a ^ 6'h02, d1, 1'b1);
    wr_data = ~d1[143:108];  // released data shows the inverse
  endtask
  // read request, then capture five half-cycle slots
  task automatic rd(input logic [5:0] a, input logic sel, output logic [179:0] s);
    to_edge(0);
    addr = a;
    rd_sel_n = ~sel;
    @(posedge in_clk);
    #0.5;
    rd_sel_n = 1'b1;
    for (int i = 0; i < 5; i++) begin
      if (i % 2 == 0) @(posedge in_clk);
      else @(posedge in_clk_n);
      #0.5;
      s[36*i +: 36] = (i % 2 == 0) ? rd_data_rise_r : rd_data_fall_r;
    end
  endtask
endmodule

/* testbench.sv */
// self-checking bench for the burst-of-four memory port
// assumes burst4_checker and host_model are compiled before it
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pll_bypass = 1'b0;
  wire in_clk, in_clk_n, rd_sel_n, wr_sel_n, echo_clock_r, echo_clock_n_r;
  wire wr_room_r, commit_pulse_r;
  wire [5:0] addr, commit_addr_r;
  wire [35:0] wr_data, rd_data_rise_r, rd_data_fall_r;
  int fail_count = 0;
  int checks = 0;
  logic [143:0] mem [64];
  // ==========================================
  // clock, design and host
  always #2 clk = ~clk;
  quad_rate_burst4_sram_port uut (.clk(clk), .sys_rst(sys_rst), .in_clk(in_clk),
    .in_clk_n(in_clk_n), .pll_bypass(pll_bypass), .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n),
    .addr(addr), .wr_data(wr_data), .rd_data_rise_r(rd_data_rise_r),
    .rd_data_fall_r(rd_data_fall_r), .echo_clock_r(echo_clock_r),
    .echo_clock_n_r(echo_clock_n_r), .wr_room_r(wr_room_r),
    .commit_addr_r(commit_addr_r), .commit_pulse_r(commit_pulse_r));
  host_model host (.sys_rst(sys_rst), .in_clk(in_clk), .in_clk_n(in_clk_n),
    .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .addr(addr), .wr_data(wr_data),
    .rd_data_rise_r(rd_data_rise_r), .rd_data_fall_r(rd_data_fall_r));
  // compare and count
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [143:0] rnd();
    return {$urandom(), $urandom(), $urandom(), $urandom(), 16'($urandom())};
  endfunction
  // five captured slots against the burst, placed by latency
  task automatic cmp(input logic [179:0] s, input logic [143:0] d, input logic sel);
    logic [179:0] e;
    e = !sel ? '0 : pll_bypass ? {d, 36'h0} : {36'h0, d};
    for (int i = 0; i < 5; i++) check(s[36*i +: 36], e[36*i +: 36]);
  endtask
  // bounded wait for the array commit of one burst
  task automatic commit_wait(input logic [5:0] a);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (commit_pulse_r !== 1'b1 && k < 100);
    if (k < 100) check(36'(commit_addr_r), 36'(a));
    else begin
      fail_count++;
      print_verdict();
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    logic [143:0] d;
    logic [143:0] d2;
    logic [179:0] s;
    logic [5:0] a;
    logic ws;
    void'($urandom(48));
    repeat (8) @(posedge clk);
    check({rd_data_rise_r | rd_data_fall_r}, 36'h0);
    check({32'h0, wr_room_r, commit_pulse_r, echo_clock_r, echo_clock_n_r}, 36'h8);
    #0.5;
    sys_rst = 1'b0;
    for (int i = 0; i < 64; i++) begin
      mem[i] = rnd();
      host.wr(6'(i), mem[i], 1'b1);
    end
    // two bursts back to back fill the buffer; commits keep their order
    repeat (30) @(posedge clk);
    d = rnd();
    d2 = rnd();
    fork
      begin
        host.wr2(6'h04, d, d2);
        @(posedge in_clk);
        #0.5;
        check(36'(wr_room_r), 36'h0);
      end
      begin
        commit_wait(6'h04);
        commit_wait(6'h06);
      end
    join
    mem[6'h04] = d;
    mem[6'h06] = d2;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      #0.5;
      pll_bypass = m[0];
      repeat (20) @(posedge clk);
      for (int t = 0; t < 40; t++) begin
        a = (t < 2) ? {6{t[0]}} : 6'($urandom());
        ws = ($urandom() % 4) != 0;
        d = rnd();
        fork
          host.wr(a, d, ws);
          begin
            @(host.wr_go);
            host.rd(a, 1'b1, s);
          end
          if (ws) commit_wait(a);
        join
        if (ws) mem[a] = d;
        cmp(s, mem[a], 1'b1);
        ws = 1'($urandom());
        host.rd(a ^ 6'h01, ws, s);
        cmp(s, mem[a ^ 6'h01], ws);
      end
    end
    print_verdict();
  end
endmodule
bind quad_rate_burst4_sram_port burst4_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) chk (
  .clk(clk), .sys_rst(sys_rst), .in_clk(in_clk), .in_clk_n(in_clk_n),
  .pll_bypass(pll_bypass), .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n),
  .rd_data_rise_r(rd_data_rise_r), .rd_data_fall_r(rd_data_fall_r),
  .echo_clock_r(echo_clock_r), .echo_clock_n_r(echo_clock_n_r), .wr_room_r(wr_room_r),
  .commit_addr_r(commit_addr_r), .commit_pulse_r(commit_pulse_r));
